/* pkg/sisli_regs.svh */
`ifndef SISLI_REGS_SVH
`define SISLI_REGS_SVH
// Characters per multiframe
`define SISLI_MF_LEN 32
// Multiframes in the lane alignment sequence
`define SISLI_ILAS_MF 4
// Consecutive comma characters the receiver needs before release
`define SISLI_CGS_NEED 4
// Width of the free running sample stamp
`define SISLI_STAMP_W 16
// Period of the reference pulse in clock cycles
`define SISLI_SYSREF_PERIOD 256
// Half period of the serial clock in clock cycles
`define SISLI_SCLK_HALF 8
// Control characters
`define SISLI_K_CGS 8'hBC
`define SISLI_K_MF_START 8'h1C
`define SISLI_K_MF_END 8'h7C
// Serial read addresses
`define SISLI_ADDR_STATUS 7'h00
`define SISLI_ADDR_STAMP_LO 7'h01
`define SISLI_ADDR_STAMP_HI 7'h02
// Serial frame bit counts
`define SISLI_CMD_BITS 5'h08
`define SISLI_FRAME_BITS 5'h10
// Pin synchroniser reset image: sysref,marker,se_sync_n,cs_n,sclk,sdi
`define SISLI_PIN_RST 6'h0C
`endif

/* pkg/sisli_pkg.sv */
`default_nettype none
package sisli_pkg;
  // Transmit side link states
  typedef enum logic [1:0] {TX_IDLE, TX_CGS, TX_ILAS, TX_DATA} sisli_tx_t;
  // Receive side link states
  typedef enum logic [1:0] {RX_CGS, RX_ILAS, RX_DATA} sisli_rx_t;
endpackage
`default_nettype wire

/* pkg/sisli_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sisli_link_if;
  // Sync and marker pins, driven by the receiver
  logic single_ended_link_sync_n;
  logic sample_marker_pos;
  logic sample_marker_neg;
  // Reference pulse pins, driven by the receiver side clocking
  logic sysref_pos;
  logic sysref_neg;
  // Serial programming pins
  logic spi_cs_n;
  logic spi_sclk;
  logic spi_sdi;
  logic serial_read_data_out_o;
  logic serial_read_data_out_oe;
  logic serial_read_data_out;
  // Lane characters, driven by the device
  logic [7:0] lane_data;
  logic lane_is_k;
  // Undriven data pin is pulled high
  assign serial_read_data_out = serial_read_data_out_oe ?
                                serial_read_data_out_o : 1'b1;
  modport device (
    input single_ended_link_sync_n, sample_marker_pos, sample_marker_neg,
    input sysref_pos, sysref_neg, spi_cs_n, spi_sclk, spi_sdi,
    output serial_read_data_out_o, serial_read_data_out_oe,
    output lane_data, lane_is_k
  );
  modport receiver (
    output single_ended_link_sync_n, sample_marker_pos, sample_marker_neg,
    output sysref_pos, sysref_neg, spi_cs_n, spi_sclk, spi_sdi,
    input serial_read_data_out, lane_data, lane_is_k
  );
endinterface
`default_nettype wire

/* core/sisli_device_end.sv */
// Notes on behaviour
// R1: Data out pin floats outside reads
// R2: Data out pin driven only during reads
// R3: Select 0 uses single-ended sync pin
// R4: Wide-code modes ignore sync for link
// R5: Sync low starts comma transmission
// R6: Sync high starts lane alignment sequence
// R7: Select 1 takes sync from pair
// R8: Marker enable tags sample at assertion
// R9: Reference pulse aligns multiframe counter
// R10: Pair sync is active low
// R11: Pair ignored unless its receiver enabled
// R12: Pair may be marker and sync together
// R13: Sync and marker pins double synchronised
`timescale 1ns/1ps
`include "sisli_regs.svh"
`default_nettype none
module sisli_device_end #(
  parameter int MF_LEN = `SISLI_MF_LEN,
  parameter int ILAS_MF = `SISLI_ILAS_MF,
  parameter int STAMP_W = `SISLI_STAMP_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link pins
  sisli_link_if.device link,
  // Configuration straps
  input wire logic sync_source_sel,
  input wire logic enc_64b66b,
  input wire logic marker_receiver_enable,
  input wire logic sample_mark_enable,
  // Payload for the data phase
  input wire logic [7:0] tx_data,
  // Status
  output logic [1:0] link_state,
  output logic nco_sync_pulse,
  output logic marker_pulse,
  output logic [STAMP_W-1:0] marker_stamp,
  output logic sysref_seen
);
  localparam int LW = $clog2(MF_LEN);
  localparam int MW = $clog2(ILAS_MF) + 1;
  localparam logic [5:0] PIN_RST = `SISLI_PIN_RST;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (MF_LEN < 4 || MF_LEN > 256 || ILAS_MF < 1 || STAMP_W < 16) begin : g_chk
    $error("sisli_device_end: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [5:0] prev_reg;

  // Differential pairs resolved to a single level
  assign pin_raw = {link.sysref_pos & ~link.sysref_neg,
                    link.sample_marker_pos & ~link.sample_marker_neg,
                    link.single_ended_link_sync_n, link.spi_cs_n,
                    link.spi_sclk, link.spi_sdi};

  genvar gi;
  for (gi = 0; gi < 6; gi++) begin : g_sync
    // R13: two flop synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        meta_reg[gi] <= PIN_RST[gi];
        sync_reg[gi] <= PIN_RST[gi];
      end else begin
        meta_reg[gi] <= pin_raw[gi];
        sync_reg[gi] <= meta_reg[gi];
      end
    end
  end

  // Previous synchronised levels for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= PIN_RST;
    end else begin
      prev_reg <= sync_reg;
    end
  end

  logic s_sysref;
  logic s_marker;
  logic s_se_n;
  logic s_cs_n;
  logic s_sdi;
  logic sclk_rise;
  logic sclk_fall;
  logic sysref_rise;
  logic marker_rise;
  logic link_sync_n;
  logic prev_link_sync_n;

  assign s_sysref = sync_reg[5];
  assign s_marker = sync_reg[4];
  assign s_se_n = sync_reg[3];
  assign s_cs_n = sync_reg[2];
  assign s_sdi = sync_reg[0];
  assign sclk_rise = sync_reg[1] & ~prev_reg[1];
  assign sclk_fall = ~sync_reg[1] & prev_reg[1];
  assign sysref_rise = s_sysref & ~prev_reg[5];
  assign marker_rise = s_marker & ~prev_reg[4];

  // ----------------------------------------------------------------
  // Sync source selection
  // ----------------------------------------------------------------
  // R3: select 0 takes the single-ended pin
  // R7: select 1 takes the pair, R10 active low
  // R11: disabled pair reads as released
  assign link_sync_n = sync_source_sel ?
                       (marker_receiver_enable ? s_marker : 1'b1) : s_se_n;
  assign prev_link_sync_n = sync_source_sel ?
                       (marker_receiver_enable ? prev_reg[4] : 1'b1) :
                       prev_reg[3];

  // ----------------------------------------------------------------
  // Multiframe counter
  // ----------------------------------------------------------------
  logic [LW-1:0] lmfc_reg;
  logic lmfc_last;

  assign lmfc_last = (lmfc_reg == LW'(MF_LEN - 1));

  // R9: reference pulse restarts the multiframe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lmfc_reg <= '0;
    end else if (sysref_rise || lmfc_last) begin
      lmfc_reg <= '0;
    end else begin
      lmfc_reg <= lmfc_reg + LW'(1);
    end
  end

  // Reference seen flag, held until reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sysref_seen <= 1'b0;
    end else if (sysref_rise) begin
      sysref_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit link state machine
  // ----------------------------------------------------------------
  sisli_pkg::sisli_tx_t tx_reg;
  logic [MW-1:0] mf_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_reg <= sisli_pkg::TX_IDLE;
      mf_reg <= '0;
    end else if (enc_64b66b) begin
      // R4: wide-code link runs without sync
      tx_reg <= sisli_pkg::TX_DATA;
      mf_reg <= '0;
    end else begin
      case (tx_reg)
        sisli_pkg::TX_IDLE: begin
          // R5: sync low starts commas
          if (!link_sync_n) begin
            tx_reg <= sisli_pkg::TX_CGS;
          end
        end
        sisli_pkg::TX_CGS: begin
          // R6: sync released, align on multiframe boundary
          if (link_sync_n && lmfc_last) begin
            tx_reg <= sisli_pkg::TX_ILAS;
            mf_reg <= '0;
          end
        end
        sisli_pkg::TX_ILAS: begin
          if (!link_sync_n) begin
            tx_reg <= sisli_pkg::TX_CGS;
          end else if (lmfc_last) begin
            if (mf_reg == MW'(ILAS_MF - 1)) begin
              tx_reg <= sisli_pkg::TX_DATA;
            end
            mf_reg <= mf_reg + MW'(1);
          end
        end
        sisli_pkg::TX_DATA: begin
          // R5: fresh sync request restarts alignment
          if (!link_sync_n) begin
            tx_reg <= sisli_pkg::TX_CGS;
          end
        end
        default: begin
          tx_reg <= sisli_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Lane character per state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.lane_data <= 8'h00;
      link.lane_is_k <= 1'b0;
    end else begin
      case (tx_reg)
        sisli_pkg::TX_CGS: begin
          link.lane_data <= `SISLI_K_CGS;
          link.lane_is_k <= 1'b1;
        end
        sisli_pkg::TX_ILAS: begin
          if (lmfc_reg == '0) begin
            link.lane_data <= `SISLI_K_MF_START;
            link.lane_is_k <= 1'b1;
          end else if (lmfc_last) begin
            link.lane_data <= `SISLI_K_MF_END;
            link.lane_is_k <= 1'b1;
          end else begin
            link.lane_data <= 8'(lmfc_reg);
            link.lane_is_k <= 1'b0;
          end
        end
        sisli_pkg::TX_DATA: begin
          link.lane_data <= tx_data;
          link.lane_is_k <= 1'b0;
        end
        default: begin
          link.lane_data <= 8'h00;
          link.lane_is_k <= 1'b0;
        end
      endcase
    end
  end

  // Status outputs; wide-code sync falling edge syncs oscillators
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_state <= 2'h0;
      nco_sync_pulse <= 1'b0;
    end else begin
      link_state <= tx_reg;
      // R4: sync still usable for oscillator alignment
      nco_sync_pulse <= enc_64b66b & prev_link_sync_n & ~link_sync_n;
    end
  end

  // ----------------------------------------------------------------
  // Sample marker
  // ----------------------------------------------------------------
  logic [STAMP_W-1:0] stamp_reg;

  // Free running sample index
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stamp_reg <= '0;
    end else begin
      stamp_reg <= stamp_reg + STAMP_W'(1);
    end
  end

  // R8: marker edge captures the sample index
  // R12: works while the pair also carries sync
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      marker_pulse <= 1'b0;
      marker_stamp <= '0;
    end else begin
      // R11: pair ignored when its receiver is off
      marker_pulse <= marker_rise & sample_mark_enable &
                      marker_receiver_enable;
      if (marker_rise && sample_mark_enable && marker_receiver_enable) begin
        marker_stamp <= stamp_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial read port
  // ----------------------------------------------------------------
  logic [4:0] bit_reg;
  logic [7:0] cmd_reg;
  logic [7:0] dout_reg;
  logic rd_reg;
  logic [7:0] cmd_next;
  logic [7:0] rd_value;

  assign cmd_next = {cmd_reg[6:0], s_sdi};

  // Read data selection
  always_comb begin
    case (cmd_next[6:0])
      `SISLI_ADDR_STATUS: rd_value = {3'h0, sysref_seen, enc_64b66b,
                                      link_sync_n, link_state};
      `SISLI_ADDR_STAMP_LO: rd_value = marker_stamp[7:0];
      `SISLI_ADDR_STAMP_HI: rd_value = marker_stamp[15:8];
      default: rd_value = 8'h00;
    endcase
  end

  // Command shift, data shift and pin enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_reg <= 5'h00;
      cmd_reg <= 8'h00;
      dout_reg <= 8'h00;
      rd_reg <= 1'b0;
    end else if (s_cs_n) begin
      // R1: no frame, pin released
      bit_reg <= 5'h00;
      rd_reg <= 1'b0;
    end else if (sclk_rise) begin
      if (bit_reg < `SISLI_CMD_BITS) begin
        cmd_reg <= cmd_next;
      end
      // R2: drive only for a read command
      if (bit_reg == `SISLI_CMD_BITS - 5'h01) begin
        rd_reg <= cmd_next[7];
        dout_reg <= rd_value;
      end
      if (bit_reg == `SISLI_FRAME_BITS - 5'h01) begin
        rd_reg <= 1'b0;
      end
      if (bit_reg < `SISLI_FRAME_BITS) begin
        bit_reg <= bit_reg + 5'h01;
      end
    end else if (sclk_fall && bit_reg > `SISLI_CMD_BITS) begin
      dout_reg <= {dout_reg[6:0], 1'b0};
    end
  end

  assign link.serial_read_data_out_o = dout_reg[7];
  assign link.serial_read_data_out_oe = rd_reg;
endmodule // sisli_device_end
`default_nettype wire

/* core/sisli_host_end.sv */
`timescale 1ns/1ps
`include "sisli_regs.svh"
`default_nettype none
module sisli_host_end #(
  parameter int CGS_NEED = `SISLI_CGS_NEED,
  parameter int ILAS_MF = `SISLI_ILAS_MF,
  parameter int SYSREF_PERIOD = `SISLI_SYSREF_PERIOD,
  parameter int SCLK_HALF = `SISLI_SCLK_HALF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link pins
  sisli_link_if.receiver link,
  // Configuration
  input wire logic use_diff_sync,
  input wire logic enc_64b66b,
  input wire logic link_restart,
  input wire logic marker_req,
  // Serial read request
  input wire logic read_start,
  input wire logic [6:0] read_addr,
  output logic read_busy,
  output logic read_done,
  output logic [7:0] read_data,
  // Received payload
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic link_up,
  output logic link_error
);
  localparam int SW = $clog2(SYSREF_PERIOD);
  localparam int HW = $clog2(SCLK_HALF) + 1;
  localparam int CW = $clog2(CGS_NEED) + 1;
  localparam int MW = $clog2(ILAS_MF) + 1;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (CGS_NEED < 1 || ILAS_MF < 1 || SYSREF_PERIOD < 8 ||
      SCLK_HALF < 6) begin : g_chk
    $error("sisli_host_end: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Reference pulse generator
  // ----------------------------------------------------------------
  logic [SW-1:0] sref_reg;

  // R9: reference pulse supply
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sref_reg <= '0;
      link.sysref_pos <= 1'b0;
      link.sysref_neg <= 1'b1;
    end else begin
      sref_reg <= (sref_reg == SW'(SYSREF_PERIOD - 1)) ? '0 :
                  sref_reg + SW'(1);
      link.sysref_pos <= (sref_reg == '0);
      link.sysref_neg <= (sref_reg != '0);
    end
  end

  // ----------------------------------------------------------------
  // Lane receive state machine
  // ----------------------------------------------------------------
  sisli_pkg::sisli_rx_t rx_reg;
  logic [CW-1:0] k_reg;
  logic [MW-1:0] mf_reg;
  logic is_comma;
  logic is_mf_end;

  assign is_comma = link.lane_is_k && link.lane_data == `SISLI_K_CGS;
  assign is_mf_end = link.lane_is_k && link.lane_data == `SISLI_K_MF_END;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_reg <= sisli_pkg::RX_CGS;
      k_reg <= '0;
      mf_reg <= '0;
      link_error <= 1'b0;
    end else if (enc_64b66b) begin
      rx_reg <= sisli_pkg::RX_DATA;
      link_error <= 1'b0;
    end else if (link_restart) begin
      rx_reg <= sisli_pkg::RX_CGS;
      k_reg <= '0;
      link_error <= 1'b0;
    end else begin
      link_error <= 1'b0;
      case (rx_reg)
        sisli_pkg::RX_CGS: begin
          k_reg <= is_comma ? k_reg + CW'(1) : '0;
          if (is_comma && k_reg >= CW'(CGS_NEED - 1)) begin
            rx_reg <= sisli_pkg::RX_ILAS;
            mf_reg <= '0;
          end
        end
        sisli_pkg::RX_ILAS: begin
          if (is_mf_end) begin
            if (mf_reg == MW'(ILAS_MF - 1)) begin
              rx_reg <= sisli_pkg::RX_DATA;
            end
            mf_reg <= mf_reg + MW'(1);
          end
        end
        sisli_pkg::RX_DATA: begin
          if (is_comma) begin
            rx_reg <= sisli_pkg::RX_CGS;
            k_reg <= '0;
            link_error <= 1'b1;
          end
        end
        default: begin
          rx_reg <= sisli_pkg::RX_CGS;
        end
      endcase
    end
  end

  // Sync level and pin steering; pair carries sync or marker
  logic sync_n;

  // R3 R5 R6: low until commas lock
  assign sync_n = enc_64b66b || rx_reg != sisli_pkg::RX_CGS;

  // R10: pair low requests sync
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.single_ended_link_sync_n <= 1'b0;
      link.sample_marker_pos <= 1'b0;
      link.sample_marker_neg <= 1'b1;
    end else begin
      link.single_ended_link_sync_n <= use_diff_sync ? 1'b0 : sync_n;
      link.sample_marker_pos <= use_diff_sync ? sync_n : marker_req;
      link.sample_marker_neg <= use_diff_sync ? ~sync_n : ~marker_req;
    end
  end

  // Payload output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      link_up <= 1'b0;
    end else begin
      rx_data <= link.lane_data;
      rx_valid <= rx_reg == sisli_pkg::RX_DATA && !link.lane_is_k;
      link_up <= rx_reg == sisli_pkg::RX_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Serial read master
  // ----------------------------------------------------------------
  logic [HW-1:0] half_reg;
  logic [4:0] rise_reg;
  logic [7:0] cmd_reg;
  logic tick;

  assign tick = read_busy && half_reg == HW'(SCLK_HALF - 1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      half_reg <= '0;
      rise_reg <= 5'h00;
      cmd_reg <= 8'h00;
      read_busy <= 1'b0;
      read_done <= 1'b0;
      read_data <= 8'h00;
      link.spi_cs_n <= 1'b1;
      link.spi_sclk <= 1'b0;
      link.spi_sdi <= 1'b0;
    end else begin
      read_done <= 1'b0;
      half_reg <= (tick || !read_busy) ? '0 : half_reg + HW'(1);
      if (!read_busy && read_start) begin
        read_busy <= 1'b1;
        rise_reg <= 5'h00;
        cmd_reg <= {1'b1, read_addr};
        link.spi_cs_n <= 1'b0;
        link.spi_sdi <= 1'b1;
      end else if (tick && !link.spi_sclk) begin
        link.spi_sclk <= 1'b1;
        rise_reg <= rise_reg + 5'h01;
        if (rise_reg >= `SISLI_CMD_BITS) begin
          read_data <= {read_data[6:0], link.serial_read_data_out};
        end
      end else if (tick) begin
        link.spi_sclk <= 1'b0;
        cmd_reg <= {cmd_reg[6:0], 1'b0};
        link.spi_sdi <= cmd_reg[6];
        if (rise_reg == `SISLI_FRAME_BITS) begin
          read_busy <= 1'b0;
          read_done <= 1'b1;
          link.spi_cs_n <= 1'b1;
        end
      end
    end
  end
endmodule // sisli_host_end
`default_nettype wire

/* tb/sisli_link_checker.sv */
`timescale 1ns/1ps
`include "sisli_regs.svh"
`default_nettype none
module sisli_link_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins from the receiver
  input wire logic single_ended_link_sync_n,
  input wire logic sample_marker_pos,
  input wire logic sample_marker_neg,
  input wire logic spi_cs_n,
  // Pins from the device
  input wire logic serial_read_data_out_oe,
  input wire logic [7:0] lane_data,
  input wire logic lane_is_k,
  // Device straps
  input wire logic sync_source_sel,
  input wire logic enc_64b66b,
  input wire logic marker_receiver_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic pair_hi;
  logic comma;
  logic pair_on;
  // Pair level and comma decode
  assign pair_hi = sample_marker_pos & ~sample_marker_neg;
  assign comma = lane_is_k && (lane_data == `SISLI_K_CGS);
  assign pair_on = !enc_64b66b && sync_source_sel && marker_receiver_enable;
  // Sync request and release held long enough to pass the synchroniser
  sequence s_se_req;
    (!enc_64b66b && !sync_source_sel && !single_ended_link_sync_n)[*8];
  endsequence
  sequence s_pair_req;
    (pair_on && !pair_hi)[*8];
  endsequence
  sequence s_pair_rel;
    (pair_on && pair_hi)[*8];
  endsequence
  property p_sdo_float;
    spi_cs_n[*4] |-> !serial_read_data_out_oe;
  endproperty
  property p_sdo_in_read;
    $rose(serial_read_data_out_oe) |-> !spi_cs_n && !$past(spi_cs_n, 8);
  endproperty
  property p_se_cgs;
    s_se_req |-> comma;
  endproperty
  property p_ilas_after_rel;
    (lane_is_k && lane_data == `SISLI_K_MF_START && !enc_64b66b &&
     !sync_source_sel) |-> $past(single_ended_link_sync_n, 4);
  endproperty
  property p_wide_no_cgs;
    enc_64b66b |-> !comma;
  endproperty
  property p_pair_cgs;
    s_pair_req |-> comma;
  endproperty
  property p_pair_ignored;
    (sync_source_sel && !marker_receiver_enable && !enc_64b66b) |-> !comma;
  endproperty
  property p_pair_rel;
    s_pair_rel ##1 s_pair_rel |-> !comma;
  endproperty
  a_sdo_float: assert property (p_sdo_float)
    else $error("data out driven while idle");
  a_sdo_in_read: assert property (p_sdo_in_read)
    else $error("data out driven outside a read");
  a_se_cgs: assert property (p_se_cgs)
    else $error("no comma under pin sync request");
  a_ilas_after_rel: assert property (p_ilas_after_rel)
    else $error("alignment start while sync low");
  a_wide_no_cgs: assert property (p_wide_no_cgs)
    else $error("comma sent in wide code mode");
  a_pair_cgs: assert property (p_pair_cgs)
    else $error("no comma under pair sync request");
  a_pair_ignored: assert property (p_pair_ignored)
    else $error("disabled pair caused comma");
  a_pair_rel: assert property (p_pair_rel)
    else $error("comma after pair release");
endmodule // sisli_link_checker
`default_nettype wire

/* tb/sisli_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sisli_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic dsync = 1'b0;
  logic enc = 1'b0;
  logic mre = 1'b0;
  logic sme = 1'b0;
  logic restart = 1'b0;
  logic mreq = 1'b0;
  logic rd_go = 1'b0;
  logic [6:0] rd_addr = 7'h00;
  logic [7:0] tx_data = 8'hA5;
  logic [1:0] state;
  logic mpulse, seen, done, up, rxv, nco, busy, lerr;
  logic [15:0] stamp;
  logic [7:0] rd_data, rx_data;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int pulses = 0;
  int n, base;
  // Sample index model, expected stamp and pulse counts
  int since = 0;
  int mark_exp = 0;
  int nco_n = 0;
  int err_n = 0;
  sisli_link_if link ();
  always #5 ref_clk = ~ref_clk;
  // Device and host facing each other
  sisli_device_end #(.MF_LEN(8)) u_sisli_device_end (.ref_clk(ref_clk),
    .rst(rst), .link(link), .sync_source_sel(dsync), .enc_64b66b(enc),
    .marker_receiver_enable(mre), .sample_mark_enable(sme),
    .tx_data(tx_data), .link_state(state), .nco_sync_pulse(nco),
    .marker_pulse(mpulse), .marker_stamp(stamp), .sysref_seen(seen));
  sisli_host_end #(.SYSREF_PERIOD(32)) u_sisli_host_end (.ref_clk(ref_clk),
    .rst(rst), .link(link), .use_diff_sync(dsync), .enc_64b66b(enc),
    .link_restart(restart), .marker_req(mreq), .read_start(rd_go),
    .read_addr(rd_addr), .read_busy(busy), .read_done(done),
    .read_data(rd_data), .rx_data(rx_data), .rx_valid(rxv), .link_up(up),
    .link_error(lerr));
  sisli_link_checker u_sisli_link_checker (.ref_clk(ref_clk), .rst(rst),
    .single_ended_link_sync_n(link.single_ended_link_sync_n),
    .sample_marker_pos(link.sample_marker_pos),
    .sample_marker_neg(link.sample_marker_neg), .spi_cs_n(link.spi_cs_n),
    .serial_read_data_out_oe(link.serial_read_data_out_oe),
    .lane_data(link.lane_data), .lane_is_k(link.lane_is_k),
    .sync_source_sel(dsync), .enc_64b66b(enc),
    .marker_receiver_enable(mre));
  // Marker pulse count and hang limit
  always @(posedge ref_clk) begin
    if (mpulse === 1'b1) pulses <= pulses + 1;
    if (nco === 1'b1) nco_n <= nco_n + 1;
    if (lerr === 1'b1) err_n <= err_n + 1;
    since <= rst ? 0 : since + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Reset both ends under a new mode
  task automatic restart_all(input logic d, input logic e, input logic m);
    @(posedge ref_clk);
    rst <= 1'b1;
    dsync <= d;
    enc <= e;
    mre <= m;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task automatic wait_up();
    for (n = 0; n < 3000 && up !== 1'b1; n++) @(posedge ref_clk);
  endtask
  // Serial read through the host
  task automatic read_reg(input logic [6:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd_addr <= a;
    rd_go <= 1'b1;
    @(posedge ref_clk);
    rd_go <= 1'b0;
    @(posedge ref_clk);
    chk({15'h0000, busy}, 16'h0001);
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge ref_clk);
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask
  // Marker edge under given enables
  task automatic mark_try(input logic m, input logic s, input int exp);
    @(posedge ref_clk);
    mre <= m;
    sme <= s;
    repeat (10) @(posedge ref_clk);
    base = pulses;
    // Marker seen four edges on: host flop, two sync, edge detect
    mark_exp = since + 4;
    mreq <= 1'b1;
    repeat (20) @(posedge ref_clk);
    mreq <= 1'b0;
    chk(16'(pulses - base), 16'(exp));
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    restart_all(1'b0, 1'b0, 1'b0);
    wait_up();
    chk({14'h0000, state}, 16'h0003);
    chk({15'h0000, seen}, 16'h0001);
    for (n = 0; n < 200 && rxv !== 1'b1; n++) @(posedge ref_clk);
    chk({8'h00, rx_data}, 16'h00A5);
    chk({15'h0000, link.serial_read_data_out}, 16'h0001);
    repeat (40) @(posedge ref_clk);
    read_reg(7'h00, 8'h17);
    read_reg(7'h7F, 8'h00);
    @(posedge ref_clk);
    restart <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({14'h0000, state}, 16'h0003);
    repeat (10) @(posedge ref_clk);
    chk({14'h0000, state}, 16'h0001);
    restart <= 1'b0;
    wait_up();
    chk({14'h0000, state}, 16'h0003);
    mark_try(1'b1, 1'b1, 1);
    chk(stamp, 16'(mark_exp));
    read_reg(7'h01, 8'(mark_exp));
    read_reg(7'h02, 8'(mark_exp >> 8));
    mark_try(1'b0, 1'b1, 0);
    mark_try(1'b1, 1'b0, 0);
    restart_all(1'b1, 1'b0, 1'b0);
    repeat (40) @(posedge ref_clk);
    chk({14'h0000, state}, 16'h0000);
    base = pulses;
    sme <= 1'b1;
    restart_all(1'b1, 1'b0, 1'b1);
    wait_up();
    chk({14'h0000, state}, 16'h0003);
    chk(16'(pulses > base), 16'h0001);
    restart_all(1'b0, 1'b1, 1'b0);
    repeat (10) @(posedge ref_clk);
    chk({14'h0000, state}, 16'h0003);
    chk(16'(nco_n), 16'h0001);
    chk(16'(err_n), 16'h0000);
    print_verdict();
  end
endmodule // sisli_bench
`default_nettype wire
